// ---- shared/stt_defs.vh ----
// Register addresses, field positions, reset values and fixed ratios of the system timebase.
`ifndef STT_DEFS_VH
`define STT_DEFS_VH

// ==========================================================================
// Special function register addresses
// ==========================================================================
`define STT_ADDR_POWER_DOWN_CONTROL   8'hF1
`define STT_ADDR_CONV_CLK_DIVIDER     8'hF6
`define STT_ADDR_SECONDS_INTERVAL     8'hF9
`define STT_ADDR_MS_INTERVAL          8'hFA
`define STT_ADDR_US_DIVIDER           8'hFB
`define STT_ADDR_MS_DIVIDER_LOW       8'hFC
`define STT_ADDR_MS_DIVIDER_HIGH      8'hFD
`define STT_ADDR_HUNDRED_MS_DIVIDER   8'hFE

// ==========================================================================
// Reset values
// ==========================================================================
`define STT_RST_POWER_DOWN_CONTROL    7'h7F
`define STT_RST_CONV_CLK_DIVIDER      7'h03
`define STT_RST_INTERVAL              7'h7F
`define STT_RST_US_DIVIDER            5'h03
`define STT_RST_MS_DIVIDER_LOW        8'h9F
`define STT_RST_MS_DIVIDER_HIGH       8'h0F
`define STT_RST_HUNDRED_MS_DIVIDER    8'h63

// ==========================================================================
// Field positions and widths
// ==========================================================================
`define STT_WRITE_TIMING_BIT          7
`define STT_TIMER_POWER_DOWN_BIT      1
`define STT_INTERVAL_WIDTH            7
`define STT_CONV_DIV_WIDTH            7
`define STT_US_DIV_WIDTH              5

// ==========================================================================
// Fixed ratios
// ==========================================================================
`define STT_MOD_RATIO                 64
`define STT_MOD_RELOAD                6'h3F

`endif

// ---- hdl/stt_divider.v ----
// Reloading divider that issues a one-cycle tick every reload plus one enabled cycles.
`timescale 1ns/1ps

module stt_divider #(
   parameter WIDTH = 8
) (
   input  wire             core_clk,
   input  wire             rstn,
   input  wire             enable,
   input  wire [WIDTH-1:0] reload,
   output wire             tick
);

   reg  [WIDTH-1:0] count;
   wire             wrap;

   // A count above a freshly lowered reload value also wraps, so the divider never runs away.
   assign wrap = enable && (count >= reload);
   assign tick = wrap;

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         count <= {WIDTH{1'b0}};
      end else if (wrap) begin
         count <= {WIDTH{1'b0}};
      end else if (enable) begin
         count <= count + {{(WIDTH-1){1'b0}}, 1'b1};
      end
   end

endmodule // stt_divider

// ---- hdl/stt_timebase.v ----
// System timebase: clock dividers, microsecond and millisecond ticks, and two interval timers.
//
// Summary of operation
// - Converter clock tick is system clock divided by seven-bit value plus one, reset 3.
// - Modulator tick is converter tick divided by 64; data rate derives from it.
// - Microsecond tick is system clock divided by five-bit value plus one, reset 3.
// - Microsecond tick is offered as the flash write duration time base.
// - Millisecond tick period is high times 256 plus low plus one cycles; low resets 0x9F.
// - Millisecond tick is offered as the flash erase duration time base.
// - Seconds timer counts 100 ms ticks, period count plus one, count resets 0x7F.
// - Seconds timer period ranges from 100 ms to 12.8 seconds.
// - Reading the seconds timer register clears its pending interrupt.
// - Pending seconds interrupt is visible for the auxiliary interrupt register.
// - Write timing select bit 7 of each interval register reads as zero.
// - Seconds write with select zero loads the new count at current expiry.
// - Seconds write with select one loads the counter right after the write.
// - Millisecond timer counts millisecond ticks, period count plus one, reset 0x7F.
// - Reading the millisecond timer register clears its pending interrupt.
// - Millisecond timer loads at expiry if select zero, immediately if select one.
// - Timer power down bit one stops the system timer logic; zero runs it.
// - Millisecond divider high byte is its own register, reset 0x0F.
// - 100 ms tick is millisecond tick divided by eight-bit value plus one, reset 0x63.
`timescale 1ns/1ps
`include "stt_defs.vh"

module stt_timebase (
   input  wire       core_clk,
   input  wire       rstn,
   input  wire [7:0] sfrAddr,
   input  wire [7:0] sfrWrData,
   input  wire       sfrWr,
   input  wire       sfrRd,
   output reg  [7:0] sfrRdData,
   output reg        sfrRdHit,
   output wire       convClkTick,
   output wire       modulatorClkTick,
   output wire       usTick,
   output wire       msTick,
   output wire       hundredMsTick,
   output wire       flashWriteTimebase,
   output wire       flashEraseTimebase,
   output wire       secondsIrq,
   output wire       msIrq,
   output wire       timerPowerDown
);

   // The two interval timers share one generate body; these indices pick the seconds
   // timer and the millisecond timer out of the per-timer vectors and arrays.
   localparam NUM_TIMERS = 2;
   localparam SEC_IDX    = 0;
   localparam MS_IDX     = 1;

   // ==========================================================================
   // Address decode
   // ==========================================================================
   function hit;
      input [7:0] addr;
      input [7:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   wire wrPowerDown = sfrWr && hit(sfrAddr, `STT_ADDR_POWER_DOWN_CONTROL);
   wire wrConvDiv   = sfrWr && hit(sfrAddr, `STT_ADDR_CONV_CLK_DIVIDER);
   wire wrUsDiv     = sfrWr && hit(sfrAddr, `STT_ADDR_US_DIVIDER);
   wire wrMsLow     = sfrWr && hit(sfrAddr, `STT_ADDR_MS_DIVIDER_LOW);
   wire wrMsHigh    = sfrWr && hit(sfrAddr, `STT_ADDR_MS_DIVIDER_HIGH);
   wire wrHundredMs = sfrWr && hit(sfrAddr, `STT_ADDR_HUNDRED_MS_DIVIDER);

   // A timer read strobe clears the pending flag of that timer, so the read decode is
   // kept per timer rather than folded into the read multiplexer.
   wire [NUM_TIMERS-1:0] tmrWr;
   wire [NUM_TIMERS-1:0] tmrRd;
   assign tmrWr[SEC_IDX] = sfrWr && hit(sfrAddr, `STT_ADDR_SECONDS_INTERVAL);
   assign tmrWr[MS_IDX]  = sfrWr && hit(sfrAddr, `STT_ADDR_MS_INTERVAL);
   assign tmrRd[SEC_IDX] = sfrRd && hit(sfrAddr, `STT_ADDR_SECONDS_INTERVAL);
   assign tmrRd[MS_IDX]  = sfrRd && hit(sfrAddr, `STT_ADDR_MS_INTERVAL);

   // ==========================================================================
   // Configuration registers
   // ==========================================================================
   reg  [6:0]                     powerDownControl;
   reg  [`STT_CONV_DIV_WIDTH-1:0] convClkDivider;
   reg  [`STT_US_DIV_WIDTH-1:0]   microsecondDivider;
   reg  [7:0]                     msDividerLow;
   reg  [7:0]                     msDividerHigh;
   reg  [7:0]                     hundredMsDivider;

   // Every configuration register is written whole in the cycle of its strobe; a divider
   // picks up a new reload value on its very next enabled cycle.
   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         powerDownControl   <= `STT_RST_POWER_DOWN_CONTROL;
         convClkDivider     <= `STT_RST_CONV_CLK_DIVIDER;
         microsecondDivider <= `STT_RST_US_DIVIDER;
         msDividerLow       <= `STT_RST_MS_DIVIDER_LOW;
         msDividerHigh      <= `STT_RST_MS_DIVIDER_HIGH;
         hundredMsDivider   <= `STT_RST_HUNDRED_MS_DIVIDER;
      end else begin
         if (wrPowerDown) begin
            powerDownControl <= sfrWrData[6:0];
         end
         if (wrConvDiv) begin
            convClkDivider <= sfrWrData[`STT_CONV_DIV_WIDTH-1:0];
         end
         if (wrUsDiv) begin
            microsecondDivider <= sfrWrData[`STT_US_DIV_WIDTH-1:0];
         end
         if (wrMsLow) begin
            msDividerLow <= sfrWrData;
         end
         if (wrMsHigh) begin
            msDividerHigh <= sfrWrData;
         end
         if (wrHundredMs) begin
            hundredMsDivider <= sfrWrData;
         end
      end
   end

   // ==========================================================================
   // Power control
   // ==========================================================================
   // Only the system timer bit acts here; the other power-down bits are stored for readback.
   // Powering down freezes the microsecond, millisecond and hundred millisecond dividers
   // and both interval timers; their counts are held, not cleared, so they resume in place.
   assign timerPowerDown = powerDownControl[`STT_TIMER_POWER_DOWN_BIT];
   wire   timerRun       = ~timerPowerDown;

   // ==========================================================================
   // Tick dividers
   // ==========================================================================
   // Each divider issues a one-cycle tick when its count reaches the reload value, so the
   // tick period is the reload value plus one enabled cycles.
   // The converter clock belongs to the converter and is not stopped by the timer bit.
   stt_divider #(.WIDTH(`STT_CONV_DIV_WIDTH)) u_convDiv (
      .core_clk (core_clk),
      .rstn     (rstn),
      .enable   (1'b1),
      .reload   (convClkDivider),
      .tick     (convClkTick)
   );

   stt_divider #(.WIDTH(6)) u_modDiv (
      .core_clk (core_clk),
      .rstn     (rstn),
      .enable   (convClkTick),
      .reload   (`STT_MOD_RELOAD),
      .tick     (modulatorClkTick)
   );

   stt_divider #(.WIDTH(`STT_US_DIV_WIDTH)) u_usDiv (
      .core_clk (core_clk),
      .rstn     (rstn),
      .enable   (timerRun),
      .reload   (microsecondDivider),
      .tick     (usTick)
   );

   stt_divider #(.WIDTH(16)) u_msDiv (
      .core_clk (core_clk),
      .rstn     (rstn),
      .enable   (timerRun),
      .reload   ({msDividerHigh, msDividerLow}),
      .tick     (msTick)
   );

   stt_divider #(.WIDTH(8)) u_hundredMsDiv (
      .core_clk (core_clk),
      .rstn     (rstn),
      .enable   (msTick),
      .reload   (hundredMsDivider),
      .tick     (hundredMsTick)
   );

   assign flashWriteTimebase = usTick;
   assign flashEraseTimebase = msTick;

   // ==========================================================================
   // Interval timers
   // ==========================================================================
   wire [NUM_TIMERS-1:0]            tmrTick;
   reg  [`STT_INTERVAL_WIDTH-1:0]   tmrValue [0:NUM_TIMERS-1];
   reg  [`STT_INTERVAL_WIDTH-1:0]   tmrCount [0:NUM_TIMERS-1];
   reg  [NUM_TIMERS-1:0]            tmrFlag;
   wire [NUM_TIMERS-1:0]            tmrExpire;

   // The seconds timer runs on the hundred millisecond tick and the millisecond timer on the
   // millisecond tick; both count down and expire on a tick that finds the count at zero.
   assign tmrTick[SEC_IDX] = hundredMsTick;
   assign tmrTick[MS_IDX]  = msTick;

   genvar i;
   generate
      for (i = 0; i < NUM_TIMERS; i = i + 1) begin : g_timer
         wire immediate = sfrWrData[`STT_WRITE_TIMING_BIT];

         assign tmrExpire[i] = tmrTick[i] && (tmrCount[i] == {`STT_INTERVAL_WIDTH{1'b0}});

         always @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               tmrValue[i] <= `STT_RST_INTERVAL;
               tmrCount[i] <= `STT_RST_INTERVAL;
            end else begin
               if (tmrWr[i]) begin
                  tmrValue[i] <= sfrWrData[`STT_INTERVAL_WIDTH-1:0];
               end
               // An immediate write outranks the expiry reload of the same cycle.
               if (tmrWr[i] && immediate) begin
                  tmrCount[i] <= sfrWrData[`STT_INTERVAL_WIDTH-1:0];
               end else if (tmrExpire[i]) begin
                  // A delayed write sits in the value register until this reload.
                  tmrCount[i] <= tmrValue[i];
               end else if (tmrTick[i]) begin
                  tmrCount[i] <= tmrCount[i] - {{(`STT_INTERVAL_WIDTH-1){1'b0}}, 1'b1};
               end
            end
         end

         // The flag is set on expiry and held until a read; an expiry in the read cycle wins.
         always @(posedge core_clk or negedge rstn) begin
            if (!rstn) begin
               tmrFlag[i] <= 1'b0;
            end else if (tmrExpire[i]) begin
               tmrFlag[i] <= 1'b1;
            end else if (tmrRd[i]) begin
               tmrFlag[i] <= 1'b0;
            end
         end
      end
   endgenerate

   // ==========================================================================
   // Pending flags
   // ==========================================================================
   // The flags leave as levels straight from their flip-flops for the interrupt register.
   assign secondsIrq = tmrFlag[SEC_IDX];
   assign msIrq      = tmrFlag[MS_IDX];

   // ==========================================================================
   // Read path
   // ==========================================================================
   // Read data is registered one cycle after the strobe and then stands until the next
   // read. Timer registers return the programmed value, not the running count, and the
   // write timing select bit always reads as zero.
   reg [7:0] next_rdData;
   reg       next_rdHit;

   always @* begin
      next_rdData = 8'h00;
      next_rdHit  = 1'b1;
      case (sfrAddr)
         `STT_ADDR_POWER_DOWN_CONTROL: begin
            next_rdData = {1'b0, powerDownControl};
         end
         `STT_ADDR_CONV_CLK_DIVIDER: begin
            next_rdData = {1'b0, convClkDivider};
         end
         `STT_ADDR_SECONDS_INTERVAL: begin
            next_rdData = {1'b0, tmrValue[SEC_IDX]};
         end
         `STT_ADDR_MS_INTERVAL: begin
            next_rdData = {1'b0, tmrValue[MS_IDX]};
         end
         `STT_ADDR_US_DIVIDER: begin
            next_rdData = {3'h0, microsecondDivider};
         end
         `STT_ADDR_MS_DIVIDER_LOW: begin
            next_rdData = msDividerLow;
         end
         `STT_ADDR_MS_DIVIDER_HIGH: begin
            next_rdData = msDividerHigh;
         end
         `STT_ADDR_HUNDRED_MS_DIVIDER: begin
            next_rdData = hundredMsDivider;
         end
         default: begin
            next_rdHit = 1'b0;
         end
      endcase
   end

   always @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         sfrRdData <= 8'h00;
         sfrRdHit  <= 1'b0;
      end else if (sfrRd) begin
         sfrRdData <= next_rdData;
         sfrRdHit  <= next_rdHit;
      end else begin
         sfrRdHit  <= 1'b0;
      end
   end

endmodule // stt_timebase

// ---- testbench/stt_timebase_props.sv ----
// Concurrent checks on the ports of the system timebase.
`timescale 1ns/1ps

module stt_props (
   input wire       core_clk,
   input wire       rstn,
   input wire [7:0] sfrAddr,
   input wire [7:0] sfrWrData,
   input wire       sfrWr,
   input wire       sfrRd,
   input wire [7:0] sfrRdData,
   input wire       sfrRdHit,
   input wire       convClkTick,
   input wire       modulatorClkTick,
   input wire       usTick,
   input wire       msTick,
   input wire       hundredMsTick,
   input wire       flashWriteTimebase,
   input wire       flashEraseTimebase,
   input wire       secondsIrq,
   input wire       msIrq,
   input wire       timerPowerDown
);
   // ==========================================================================
   // Decode and sequences
   // ==========================================================================
   wire isMapped = sfrAddr == 8'hF1 || sfrAddr == 8'hF6 || (sfrAddr >= 8'hF9 && sfrAddr <= 8'hFE);
   wire isTimer  = sfrAddr == 8'hF9 || sfrAddr == 8'hFA;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   sequence sRdMs;
      sfrRd && sfrAddr == 8'hFA && !msTick;
   endsequence
   sequence sRdSec;
      sfrRd && sfrAddr == 8'hF9 && !hundredMsTick;
   endsequence
   // ==========================================================================
   // Assertions
   // ==========================================================================
   a_unmapped_read: assert property (sfrRd && !isMapped |=> !sfrRdHit && sfrRdData == 8'h00)
      else $error("unmapped read answered");
   a_mapped_read_hit: assert property (sfrRd && isMapped |=> sfrRdHit)
      else $error("mapped read without hit");
   a_write_sel_zero: assert property (sfrRd && isTimer |=> !sfrRdData[7])
      else $error("write timing select read as one");
   a_ms_read_clear: assert property (sRdMs |=> !msIrq)
      else $error("ms flag not cleared by read");
   a_sec_read_clear: assert property (sRdSec |=> !secondsIrq)
      else $error("seconds flag not cleared by read");
   a_ms_flag_holds: assert property (msIrq && !(sfrRd && sfrAddr == 8'hFA) |=> msIrq)
      else $error("ms flag dropped without read");
   a_sec_flag_rise: assert property ($rose(secondsIrq) |-> $past(hundredMsTick))
      else $error("seconds flag set without 100 ms tick");
   a_pd_quiet: assert property (timerPowerDown |-> !usTick && !msTick && !hundredMsTick)
      else $error("tick while powered down");
   a_pd_bit_write: assert property (sfrWr && sfrAddr == 8'hF1 |=> timerPowerDown == $past(sfrWrData[1]))
      else $error("power down bit not taken");
   a_flash_bases: assert property (flashWriteTimebase == usTick && flashEraseTimebase == msTick)
      else $error("flash time base differs");
   a_mod_on_conv: assert property (modulatorClkTick |-> convClkTick)
      else $error("modulator tick off the converter tick");
endmodule // stt_props

// ---- testbench/tb_stt_timebase.sv ----
// Self-checking bench for the system timebase.
`timescale 1ns/1ps

module tb_stt_timebase;
   logic       core_clk  = 1'b0;
   logic       rstn      = 1'b0;
   logic [7:0] sfrAddr   = 8'h00;
   logic [7:0] sfrWrData = 8'h00;
   logic       sfrWr     = 1'b0;
   logic       sfrRd     = 1'b0;
   logic [6:0] prevV     = 7'h00;
   wire  [7:0] sfrRdData;
   wire        sfrRdHit, convClkTick, modulatorClkTick, usTick, msTick, hundredMsTick;
   wire        flashWriteTimebase, flashEraseTimebase, secondsIrq, msIrq, timerPowerDown;
   wire  [6:0] watch = {msIrq, secondsIrq, hundredMsTick, msTick, usTick, modulatorClkTick, convClkTick};
   logic [7:0] addrs [8] = '{8'hF1, 8'hF6, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE};
   logic [7:0] rstv  [8] = '{8'h7F, 8'h03, 8'h7F, 8'h7F, 8'h03, 8'h9F, 8'h0F, 8'h63};
   logic [7:0] tv    [2] = '{8'h7F, 8'h7F};
   int         miscompares = 0;
   int         samples_checked = 0;
   int         cyc = 0;
   int         lastRise [7];
   int         gapv [7];
   int         rises [7];
   int         seedDummy, v, n, m, p, r0;

   always #25 core_clk = ~core_clk;

   stt_timebase dut (.core_clk(core_clk), .rstn(rstn), .sfrAddr(sfrAddr), .sfrWrData(sfrWrData),
      .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData), .sfrRdHit(sfrRdHit), .convClkTick(convClkTick),
      .modulatorClkTick(modulatorClkTick), .usTick(usTick), .msTick(msTick), .hundredMsTick(hundredMsTick),
      .flashWriteTimebase(flashWriteTimebase), .flashEraseTimebase(flashEraseTimebase),
      .secondsIrq(secondsIrq), .msIrq(msIrq), .timerPowerDown(timerPowerDown));

   // ==========================================================================
   // Rise monitor: cycles between successive rises of each watched output
   // ==========================================================================
   always @(negedge core_clk) begin
      cyc = cyc + 1;
      for (int i = 0; i < 7; i++) begin
         if (watch[i] === 1'b1 && !prevV[i]) begin
            gapv[i] = cyc - lastRise[i];
            lastRise[i] = cyc;
            rises[i]++;
         end
         prevV[i] = watch[i] === 1'b1;
      end
   end

   // ==========================================================================
   // Tasks
   // ==========================================================================
   task automatic end_sim;
      $display("checks %0d, mismatches %0d", samples_checked, miscompares);
      if (miscompares == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      #2 {sfrWr, sfrAddr, sfrWrData} = {1'b1, a, d};
      @(posedge core_clk);
      #2 sfrWr = 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
      @(posedge core_clk);
      #2 {sfrRd, sfrAddr} = {1'b1, a};
      @(posedge core_clk);
      #2 sfrRd = 1'b0;
      chk(sfrRdData, e);
      chk(sfrRdHit, h);
   endtask

   // Waits for the next rise of a watched output; a timer flag is then cleared by a read.
   task automatic gap(input int w, input int exp, input int bound);
      int c;
      c = rises[w];
      for (int k = 0; k < bound && rises[w] == c; k++) @(negedge core_clk);
      if (rises[w] == c) begin
         miscompares++;
         $display("wrong value at %0t: no rise on output %0d", $time, w);
         end_sim();
      end else begin
         if (w >= 5) rd(w == 5 ? 8'hF9 : 8'hFA, tv[w-5], 1'b1);
         if (exp >= 0) chk(gapv[w], exp);
      end
   endtask

   // ==========================================================================
   // Main sequence
   // ==========================================================================
   initial begin
      seedDummy = $urandom(84782);
      repeat (5) @(posedge core_clk);
      #2 rstn = 1'b1;
      foreach (addrs[i]) rd(addrs[i], rstv[i], 1'b1);
      rd(8'hF2, 8'h00, 1'b0);
      gap(0, -1, 20);
      gap(0, 4, 20);
      repeat (100) @(negedge core_clk);
      chk(rises[2] + rises[3], 0);
      wr(8'hF1, 8'h7D);
      chk(timerPowerDown, 1'b0);
      for (int j = 0; j < 2; j++) begin
         v = $urandom_range(15, 1);
         wr(8'hF6, v);
         rd(8'hF6, v, 1'b1);
         gap(0, -1, 40);
         gap(0, v + 1, 40);
         gap(1, -1, 2000);
         gap(1, 64 * (v + 1), 2000);
         v = $urandom_range(31, 1);
         wr(8'hFB, v);
         rd(8'hFB, v, 1'b1);
         gap(2, -1, 40);
         gap(2, v + 1, 40);
      end
      wr(8'hFD, 8'h01);
      wr(8'hFC, 8'h00);
      gap(3, -1, 5000);
      gap(3, 257, 600);
      wr(8'hFD, 8'h00);
      wr(8'hFC, 8'h09);
      gap(3, -1, 600);
      gap(3, 10, 40);
      wr(8'hFE, 8'h02);
      gap(4, -1, 100);
      gap(4, 30, 100);
      for (int t = 0; t < 2; t++) begin
         p = t ? 10 : 30;
         n = $urandom_range(3, 0);
         m = (n + 2) % 4;
         rd(t ? 8'hFA : 8'hF9, tv[t], 1'b1);
         rd(t ? 8'hFA : 8'hF9, tv[t], 1'b1);
         tv[t] = n;
         wr(t ? 8'hFA : 8'hF9, 8'h80 | n);
         gap(5 + t, -1, (n + 2) * p);
         gap(5 + t, (n + 1) * p, 200);
         tv[t] = m;
         wr(t ? 8'hFA : 8'hF9, m);
         gap(5 + t, (n + 1) * p, 200);
         gap(5 + t, (m + 1) * p, 200);
      end
      wr(8'hF1, 8'h7F);
      r0 = rises[3];
      repeat (50) @(negedge core_clk);
      chk(rises[3], r0);
      end_sim();
   end
endmodule // tb_stt_timebase

bind stt_timebase stt_props props (.core_clk(core_clk), .rstn(rstn), .sfrAddr(sfrAddr),
   .sfrWrData(sfrWrData), .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdData(sfrRdData), .sfrRdHit(sfrRdHit),
   .convClkTick(convClkTick), .modulatorClkTick(modulatorClkTick), .usTick(usTick), .msTick(msTick),
   .hundredMsTick(hundredMsTick), .flashWriteTimebase(flashWriteTimebase),
   .flashEraseTimebase(flashEraseTimebase), .secondsIrq(secondsIrq), .msIrq(msIrq),
   .timerPowerDown(timerPowerDown));
